// ===== dv/bidirectional_gpio_port_tb_top.sv
// Self-checking testbench of the GPIO port through its AXI4-Lite registers.
`timescale 1ns/1ps
module bidirectional_gpio_port_tb_top;
  import gpx_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pin, ext_en = 8'h00, ext_val = 8'h00;
  logic [7:0] int_en = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic sleep = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  gpx_pad_t pad_o;
  int errors = 0;
  int n_checks = 0;
  always #2.5 aclk = ~aclk;
  gpx_port i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_i(pin), .sleep_clamp_i(sleep),
    .ext_int_en_i(int_en), .pad_o(pad_o));
  gpx_ext_model i_ext (.aclk(aclk), .pad(pad_o), .ext_en(ext_en), .ext_val(ext_val),
    .pin(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = GPX_RESP_OKAY, input logic [3:0] s = 4'hf);
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er, "bresp");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = GPX_RESP_OKAY);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp, "rdata");
    chk(rresp, er, "rresp");
  endtask
  task automatic t_drive();
    wr(GPX_OFS_OUTPUT_VALUE, 32'ha5);
    wr(GPX_OFS_DIRECTION, 32'hff);
    chk(pad_o.oe, 8'hff, "oe");
    chk(pad_o.o, 8'ha5, "o");
    rd(GPX_OFS_INPUT_SAMPLE, 32'ha5);
    wr(GPX_OFS_OUTPUT_VALUE, 32'h00, GPX_RESP_OKAY, 4'he);
    rd(GPX_OFS_OUTPUT_VALUE, 32'ha5);
  endtask
  task automatic t_toggle();
    wr(GPX_OFS_INPUT_SAMPLE, 32'h0f);
    rd(GPX_OFS_OUTPUT_VALUE, 32'haa);
    wr(GPX_OFS_INPUT_SAMPLE, 32'h00);
    rd(GPX_OFS_OUTPUT_VALUE, 32'haa);
    rd(GPX_OFS_INPUT_SAMPLE, 32'haa);
  endtask
  task automatic t_setclr();
    wr(GPX_OFS_DIR_CLR, 32'h01);
    rd(GPX_OFS_DIRECTION, 32'hfe);
    wr(GPX_OFS_DIR_SET, 32'h01);
    rd(GPX_OFS_DIRECTION, 32'hff);
    wr(GPX_OFS_OUT_SET, 32'h01);
    wr(GPX_OFS_OUT_CLR, 32'h80);
    rd(GPX_OFS_OUTPUT_VALUE, 32'h2b);
  endtask
  task automatic t_pullup();
    wr(GPX_OFS_DIRECTION, 32'h00);
    chk(pad_o.pu, 8'h2b, "pu");
    chk(pad_o.oe, 8'h00, "oe");
    wr(GPX_OFS_MCU_CONTROL, 32'h01);
    chk(pad_o.pu, 8'h00, "pu");
    rd(GPX_OFS_MCU_CONTROL, 32'h01);
    wr(GPX_OFS_MCU_CONTROL, 32'h00);
    wr(GPX_OFS_DIRECTION, 32'h0f);
    chk(pad_o.pu, 8'h20, "pu");
  endtask
  task automatic t_input();
    wr(GPX_OFS_DIRECTION, 32'h00);
    ext_en <= 8'hff;
    ext_val <= 8'h3c;
    repeat (2) @(posedge aclk);
    rd(GPX_OFS_INPUT_SAMPLE, 32'h3c);
    ext_val <= 8'hff;
    sleep <= 1'b1;
    int_en <= 8'h0f;
    repeat (2) @(posedge aclk);
    rd(GPX_OFS_INPUT_SAMPLE, 32'h0f);
    sleep <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(GPX_OFS_INPUT_SAMPLE, 32'hff);
  endtask
  task automatic t_unmapped_reset();
    wr(8'h20, 32'hff, GPX_RESP_SLVERR);
    rd(8'h20, 32'h0, GPX_RESP_SLVERR);
    wr(GPX_OFS_DIRECTION, 32'hff);
    @(posedge aclk);
    #1 aresetn = 1'b0;
    #1 chk(pad_o.oe, 8'h00, "oe async");
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(GPX_OFS_OUTPUT_VALUE, 32'h0);
    rd(GPX_OFS_DIRECTION, 32'h0);
    rd(GPX_OFS_MCU_CONTROL, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    // A falling reset at time zero clears the pad flops before any clock edge.
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_drive();
    t_toggle();
    t_setclr();
    t_pullup();
    t_input();
    t_unmapped_reset();
    report_and_stop();
  end
  // Whole run needs about 150 cycles; this bound leaves ample margin.
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    report_and_stop();
  end
endmodule

// ===== dv/gpx_ext_model.sv
// Model of the external circuitry that hangs on the eight port pins.
`timescale 1ns/1ps
module gpx_ext_model (
  input wire logic aclk,
  input wire gpx_pkg::gpx_pad_t pad,
  input wire logic [gpx_pkg::GPX_PORT_W-1:0] ext_en,
  input wire logic [gpx_pkg::GPX_PORT_W-1:0] ext_val,
  output logic [gpx_pkg::GPX_PORT_W-1:0] pin
);
  import gpx_pkg::*;
  logic [GPX_PORT_W-1:0] float_q = 8'h55;
  // A floating pin must not settle quietly, so it flickers every cycle.
  always @(posedge aclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < GPX_PORT_W; i++) begin
      pin[i] = pad.oe[i] ? pad.o[i] : ext_en[i] ? ext_val[i] : pad.pu[i] ? 1'b1 : float_q[i];
    end
  end
endmodule

// ===== hw/gpx_pkg.sv
// Package with the constants and carrier types of the bidirectional GPIO port.
package gpx_pkg;

  localparam int GPX_PORT_W = 8;
  localparam int GPX_ADDR_W = 8;
  localparam int GPX_DATA_W = 32;

  // Byte offsets of the registers on the AXI4-Lite bus.
  localparam logic [GPX_ADDR_W-1:0] GPX_OFS_OUTPUT_VALUE = 8'h00;
  localparam logic [GPX_ADDR_W-1:0] GPX_OFS_DIRECTION = 8'h04;
  localparam logic [GPX_ADDR_W-1:0] GPX_OFS_INPUT_SAMPLE = 8'h08;
  localparam logic [GPX_ADDR_W-1:0] GPX_OFS_MCU_CONTROL = 8'h0c;
  localparam logic [GPX_ADDR_W-1:0] GPX_OFS_DIR_SET = 8'h10;
  localparam logic [GPX_ADDR_W-1:0] GPX_OFS_DIR_CLR = 8'h14;
  localparam logic [GPX_ADDR_W-1:0] GPX_OFS_OUT_SET = 8'h18;
  localparam logic [GPX_ADDR_W-1:0] GPX_OFS_OUT_CLR = 8'h1c;

  // Field position of the global pull-up disable in the control register.
  localparam int GPX_PULLUP_DIS_BIT = 0;

  // Reset values.
  localparam logic [GPX_PORT_W-1:0] GPX_PORT_RST = 8'h00;
  localparam logic GPX_PULLUP_DIS_RST = 1'b0;

  localparam logic [1:0] GPX_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPX_RESP_SLVERR = 2'h2;

  // Pad-facing signals of every pin of the port.
  typedef struct packed {
    logic [GPX_PORT_W-1:0] oe;
    logic [GPX_PORT_W-1:0] o;
    logic [GPX_PORT_W-1:0] pu;
  } gpx_pad_t;

  // Register state of the port and its bus slave; the pad flops are kept apart.
  typedef struct packed {
    logic [GPX_PORT_W-1:0] out_val;
    logic [GPX_PORT_W-1:0] dir;
    logic [GPX_PORT_W-1:0] sample;
    logic pullup_dis;
    logic aw_have;
    logic w_have;
    logic [GPX_ADDR_W-1:0] waddr;
    logic [GPX_DATA_W-1:0] wdata;
    logic wlane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [GPX_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } gpx_state_t;

endpackage

// ===== hw/gpx_port.sv
// One eight-pin bidirectional GPIO port with an AXI4-Lite register slave.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

// Operation
// - Direction bit one means output, zero input.
// - Input with output bit one enables pull-up.
// - Pull-up off when output bit zero or output.
// - Reset tri-states all pins asynchronously.
// - Output pin drives its output-value bit.
// - Writing one to sample register toggles output.
// - Three port registers; sample read-only, others read/write.
// - Global pull-up disable turns all pull-ups off.
// - Bit set and clear touch only addressed bits.
// - Sample register shows pin level in any direction.
// - Latch open while clock high, then flop.
// - Pin change seen after half to 1.5 cycles.
// - Written pin value samples one cycle later.
// - Deep sleep clamps digital input to ground.
// - Enabled external interrupt overrides the sleep clamp.
// - Clamp release can flag disabled edge interrupts.
// - Alternate functions leave other pins usable.
module gpx_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [gpx_pkg::GPX_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [gpx_pkg::GPX_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gpx_pkg::GPX_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [gpx_pkg::GPX_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [gpx_pkg::GPX_PORT_W-1:0] pin_i,
  input wire logic sleep_clamp_i,
  input wire logic [gpx_pkg::GPX_PORT_W-1:0] ext_int_en_i,
  output gpx_pkg::gpx_pad_t pad_o
);
  import gpx_pkg::*;

  gpx_state_t st_q;
  gpx_state_t st_d;
  gpx_pad_t pad_q;
  gpx_pad_t pad_d;
  logic [GPX_PORT_W-1:0] in_eff;
  logic [GPX_PORT_W-1:0] sync_latch;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic [GPX_PORT_W-1:0] wbyte;

  // Per-pin input path; pins are fully independent of one another.
  // pins stay independent
  for (genvar n = 0; n < GPX_PORT_W; n++) begin : g_pin
    assign in_eff[n] = pin_i[n] & ~(sleep_clamp_i & ~ext_int_en_i[n]);

    // half to 1.5 cycles
    // The latch is the first synchroniser stage; only the sample flop reads it.
    always_latch begin
      if (aclk) begin
        sync_latch[n] <= in_eff[n];
      end
    end
  end

  assign aw_hs = s_axi_awvalid & st_q.awready;
  assign w_hs = s_axi_wvalid & st_q.wready;
  assign ar_hs = s_axi_arvalid & st_q.arready;
  assign wr_go = st_q.aw_have & st_q.w_have & ~st_q.bvalid;
  assign wbyte = st_q.wlane0 ? st_q.wdata[GPX_PORT_W-1:0] : GPX_PORT_RST;

  always_comb begin
    st_d = st_q;

    st_d.sample = sync_latch;

    if (aw_hs) begin
      st_d.aw_have = 1'b1;
      st_d.waddr = s_axi_awaddr;
    end
    if (w_hs) begin
      st_d.w_have = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wlane0 = s_axi_wstrb[0];
    end

    if (wr_go) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = GPX_RESP_OKAY;
      case (st_q.waddr)
        GPX_OFS_OUTPUT_VALUE: begin
          if (st_q.wlane0) begin
            st_d.out_val = wbyte;
          end
        end
        GPX_OFS_DIRECTION: begin
          if (st_q.wlane0) begin
            st_d.dir = wbyte;
          end
        end
        GPX_OFS_INPUT_SAMPLE: begin
          st_d.out_val = st_q.out_val ^ wbyte;
        end
        GPX_OFS_MCU_CONTROL: begin
          if (st_q.wlane0) begin
            st_d.pullup_dis = st_q.wdata[GPX_PULLUP_DIS_BIT];
          end
        end
        GPX_OFS_DIR_SET: begin
          st_d.dir = st_q.dir | wbyte;
        end
        GPX_OFS_DIR_CLR: begin
          st_d.dir = st_q.dir & ~wbyte;
        end
        GPX_OFS_OUT_SET: begin
          st_d.out_val = st_q.out_val | wbyte;
        end
        GPX_OFS_OUT_CLR: begin
          st_d.out_val = st_q.out_val & ~wbyte;
        end
        default: begin
          st_d.bresp = GPX_RESP_SLVERR;
        end
      endcase
    end else if (st_q.bvalid & s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Address is refused while an address is held, data while data is held, and both while a write is answered.
    st_d.awready = ~st_d.aw_have & ~st_d.bvalid;
    st_d.wready = ~st_d.w_have & ~st_d.bvalid;

    if (ar_hs) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = GPX_RESP_OKAY;
      st_d.rdata = '0;
      case (s_axi_araddr)
        GPX_OFS_OUTPUT_VALUE: st_d.rdata[GPX_PORT_W-1:0] = st_q.out_val;
        GPX_OFS_DIRECTION: st_d.rdata[GPX_PORT_W-1:0] = st_q.dir;
        GPX_OFS_INPUT_SAMPLE: st_d.rdata[GPX_PORT_W-1:0] = st_q.sample;
        GPX_OFS_MCU_CONTROL: st_d.rdata[GPX_PULLUP_DIS_BIT] = st_q.pullup_dis;
        GPX_OFS_DIR_SET, GPX_OFS_DIR_CLR, GPX_OFS_OUT_SET, GPX_OFS_OUT_CLR: begin
          st_d.rdata = '0;
        end
        default: st_d.rresp = GPX_RESP_SLVERR;
      endcase
    end else if (st_q.rvalid & s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    st_d.arready = ~st_d.rvalid;

    pad_d.oe = st_d.dir;
    pad_d.o = st_d.out_val;
    pad_d.pu = ~st_d.dir & st_d.out_val & {GPX_PORT_W{~st_d.pullup_dis}};
  end

  // all register bits reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // async tri-state on reset
  // Only the pad flops clear without a clock, so pins float even with no clock.
  always_ff @(posedge aclk or negedge aresetn) begin
    if (!aresetn) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad_d;
    end
  end

  // pad changes at the write edge, so its level samples one cycle later.
  assign pad_o = pad_q;
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // Checks on the pads, the register effects and the input path.
  property p_dir_oe;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> pad_o.oe == st_q.dir;
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("Driver enable differs from direction.");

  property p_pullup;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> pad_o.pu == (~st_q.dir & st_q.out_val & {GPX_PORT_W{~st_q.pullup_dis}});
  endproperty
  a_pullup: assert property (p_pullup) else $error("Pull-up enable is wrong.");

  property p_pullup_dis_off;
    @(posedge aclk) disable iff (!aresetn)
      st_q.pullup_dis |-> pad_o.pu == '0;
  endproperty
  a_pullup_dis_off: assert property (p_pullup_dis_off) else $error("Pull-up on while disabled.");

  property p_reset_hiz;
    @(posedge aclk) !aresetn |-> pad_o.oe == '0 && pad_o.pu == '0;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("Pins driven during reset.");

  property p_drive_val;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> (pad_o.o & pad_o.oe) == (st_q.out_val & st_q.dir);
  endproperty
  a_drive_val: assert property (p_drive_val) else $error("Driven level is wrong.");

  property p_toggle;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && st_q.waddr == GPX_OFS_INPUT_SAMPLE |=>
        st_q.out_val == ($past(st_q.out_val) ^ $past(wbyte)) && st_q.dir == $past(st_q.dir);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Toggle write misbehaved.");

  property p_dir_set;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && st_q.waddr == GPX_OFS_DIR_SET |=> st_q.dir == ($past(st_q.dir) | $past(wbyte));
  endproperty
  a_dir_set: assert property (p_dir_set) else $error("Direction set touched other bits.");

  property p_read_sample;
    @(posedge aclk) disable iff (!aresetn)
      ar_hs && s_axi_araddr == GPX_OFS_INPUT_SAMPLE |=>
        s_axi_rvalid && s_axi_rdata[GPX_PORT_W-1:0] == $past(st_q.sample);
  endproperty
  a_read_sample: assert property (p_read_sample) else $error("Sample read is wrong.");

  property p_sync_delay;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) ##1 1'b1 |-> st_q.sample == $past(in_eff);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("Synchroniser delay is wrong.");

  property p_clamp;
    @(posedge aclk) disable iff (!aresetn)
      sleep_clamp_i |=> (st_q.sample & ~$past(ext_int_en_i)) == '0;
  endproperty
  a_clamp: assert property (p_clamp) else $error("Clamped input not grounded.");

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
      wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("Write answer missing.");

  property p_pu_output;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> (pad_o.pu & (st_q.dir | ~st_q.out_val)) == '0;
  endproperty
  a_pu_output: assert property (p_pu_output) else $error("Pull-up on for output or low bit.");

  property p_plain_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && st_q.wlane0 && st_q.waddr == GPX_OFS_DIRECTION |=>
        st_q.dir == $past(wbyte) && st_q.out_val == $past(st_q.out_val);
  endproperty
  a_plain_write: assert property (p_plain_write) else $error("Direction write is wrong.");

  property p_read_dir;
    @(posedge aclk) disable iff (!aresetn)
      ar_hs && s_axi_araddr == GPX_OFS_DIRECTION |=>
        s_axi_rvalid && s_axi_rdata[GPX_PORT_W-1:0] == $past(st_q.dir) &&
        s_axi_rdata[GPX_DATA_W-1:GPX_PORT_W] == '0;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("Direction read is wrong.");

  property p_dir_clr;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && st_q.waddr == GPX_OFS_DIR_CLR |=>
        st_q.dir == ($past(st_q.dir) & ~$past(wbyte));
  endproperty
  a_dir_clr: assert property (p_dir_clr) else $error("Direction clear touched other bits.");

  property p_out_set;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && st_q.waddr == GPX_OFS_OUT_SET |=>
        st_q.out_val == ($past(st_q.out_val) | $past(wbyte)) && st_q.dir == $past(st_q.dir);
  endproperty
  a_out_set: assert property (p_out_set) else $error("Output set touched other bits.");

  property p_out_clr;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && st_q.waddr == GPX_OFS_OUT_CLR |=>
        st_q.out_val == ($past(st_q.out_val) & ~$past(wbyte)) && st_q.dir == $past(st_q.dir);
  endproperty
  a_out_clr: assert property (p_out_clr) else $error("Output clear touched other bits.");

  // Enabled interrupt pins must pass the pin level even while the clamp is raised.
  property p_clamp_override;
    @(posedge aclk) disable iff (!aresetn)
      sleep_clamp_i |=> ((st_q.sample ^ $past(pin_i)) & $past(ext_int_en_i)) == '0;
  endproperty
  a_clamp_override: assert property (p_clamp_override) else $error("Clamp not overridden.");

  property p_reset_regs;
    @(posedge aclk) !aresetn |=> st_q.out_val == '0 && st_q.dir == '0 && !st_q.pullup_dis;
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("Register not cleared by reset.");

  property p_ar_refuse;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("Read address taken while answering.");

  c_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_go && st_q.waddr == GPX_OFS_INPUT_SAMPLE);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn)
    ar_hs ##1 s_axi_rvalid && s_axi_rready);
  c_clamp_override: cover property (@(posedge aclk) disable iff (!aresetn)
    sleep_clamp_i && (ext_int_en_i & pin_i) != '0);
  c_clamp_release: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(sleep_clamp_i));
  c_out_clear: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_go && st_q.waddr == GPX_OFS_OUT_CLR);

endmodule
